// ---- rtl/phy_bank_pkg.sv ----
package phy_bank_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_BASIC_CONTROL = 8'hE4;
  localparam logic [7:0] OFS_BASIC_STATUS = 8'hE6;
  localparam logic [7:0] OFS_ID_LOW = 8'hE8;
  localparam logic [7:0] OFS_ID_HIGH = 8'hEA;
  localparam logic [7:0] OFS_ADVERTISE = 8'hEC;
  localparam logic [7:0] OFS_PORT_CONTROL = 8'hF6;

  // basic control field positions
  localparam int unsigned BC_LOOPBACK = 14;
  localparam int unsigned BC_FORCE_100 = 13;
  localparam int unsigned BC_AN_ENABLE = 12;
  localparam int unsigned BC_RSVD_11 = 11;
  localparam int unsigned BC_RSVD_10 = 10;
  localparam int unsigned BC_AN_RESTART = 9;
  localparam int unsigned BC_FORCE_FULL = 8;
  localparam int unsigned BC_XOVER_ALGO = 5;
  localparam int unsigned BC_FORCE_MDI = 4;
  localparam int unsigned BC_XOVER_DIS = 3;
  localparam int unsigned BC_RSVD_2 = 2;
  localparam int unsigned BC_TX_DIS = 1;
  localparam int unsigned BC_LED_DIS = 0;

  // basic status field positions
  localparam int unsigned BS_AN_DONE = 5;
  localparam int unsigned BS_LINK_UP = 2;

  // advertisement field positions, ability nibble sits at 8:5
  localparam int unsigned AD_PAUSE = 10;
  localparam int unsigned AD_RSVD_9 = 9;
  localparam int unsigned AD_ABIL_LSB = 5;

  // port control word field positions
  localparam int unsigned PC_LED_OFF = 15;
  localparam int unsigned PC_TX_DIS = 14;
  localparam int unsigned PC_AN_RESTART = 13;
  localparam int unsigned PC_RSVD_12 = 12;
  localparam int unsigned PC_RSVD_11 = 11;
  localparam int unsigned PC_XOVER_DIS = 10;
  localparam int unsigned PC_FORCE_MDI = 9;
  localparam int unsigned PC_RSVD_8 = 8;
  localparam int unsigned PC_AN_ENABLE = 7;
  localparam int unsigned PC_FORCE_100 = 6;
  localparam int unsigned PC_FORCE_FULL = 5;
  localparam int unsigned PC_PAUSE = 4;

  // reset and fixed values
  localparam logic [15:0] BASIC_CONTROL_RST = 16'h3120;
  localparam logic [15:0] BASIC_STATUS_FIXED = 16'h3050;
  localparam logic [15:0] ADVERTISE_RST = 16'h05E1;
  localparam logic [4:0] SELECTOR_FIELD = 5'h01;
  localparam logic [3:0] ADV_ABIL_RST = 4'hF;

  // one-hot negotiation states
  typedef enum logic [3:0] {
    NEG_IDLE = 4'b0001,
    NEG_RUN  = 4'b0010,
    NEG_DONE = 4'b0100,
    NEG_FAIL = 4'b1000
  } neg_state_e;

  // host register request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } reg_req_s;

  // control storage shared by the aliased words
  typedef struct packed {
    logic loopback;
    logic force_100;
    logic an_enable;
    logic [2:0] bc_rsvd;
    logic force_full;
    logic xover_algo;
    logic force_mdi;
    logic xover_dis;
    logic tx_dis;
    logic led_dis;
    logic adv_pause;
    logic adv_rsvd;
    logic [3:0] adv_abil;
    logic [2:0] pc_rsvd;
  } ctrl_s;

endpackage : phy_bank_pkg

// ---- rtl/negotiation_sequencer.sv ----
`timescale 1ns/100ps
module negotiation_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic restart,
  input wire logic link_up,
  input wire logic partner_valid,
  input wire logic [4:0] partner_ability,
  input wire logic [4:0] local_ability,
  output logic complete,
  output logic failed,
  output logic pause_agreed,
  output logic [3:0] common
);

  phy_bank_pkg::neg_state_e state_q, state_d;
  logic [3:0] common_q, common_d;
  logic pause_q, pause_d;
  logic [3:0] both;

  assign both = partner_ability[3:0] & local_ability[3:0];

  // next state of the exchange
  always_comb begin
    state_d = state_q;
    common_d = common_q;
    pause_d = pause_q;
    if (!enable) begin
      state_d = phy_bank_pkg::NEG_IDLE;
    end else if (restart) begin
      state_d = phy_bank_pkg::NEG_RUN;
    end else begin
      case (state_q)
        phy_bank_pkg::NEG_IDLE: state_d = phy_bank_pkg::NEG_RUN;
        phy_bank_pkg::NEG_RUN: begin
          if (partner_valid) begin
            common_d = both;
            pause_d = partner_ability[4] & local_ability[4];
            state_d = (both != 4'h0) ? phy_bank_pkg::NEG_DONE : phy_bank_pkg::NEG_FAIL;
          end
        end
        phy_bank_pkg::NEG_DONE: begin
          if (!link_up) begin
            state_d = phy_bank_pkg::NEG_RUN;
          end
        end
        phy_bank_pkg::NEG_FAIL: state_d = phy_bank_pkg::NEG_FAIL;
        default: state_d = phy_bank_pkg::NEG_IDLE;
      endcase
    end
    if (state_d != phy_bank_pkg::NEG_DONE) begin
      pause_d = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= phy_bank_pkg::NEG_IDLE;
      common_q <= 4'h0;
      pause_q <= 1'b0;
    end else begin
      state_q <= state_d;
      common_q <= common_d;
      pause_q <= pause_d;
    end
  end

  assign complete = (state_q == phy_bank_pkg::NEG_DONE);
  assign failed = (state_q == phy_bank_pkg::NEG_FAIL);
  assign pause_agreed = pause_q;
  assign common = common_q;

endmodule : negotiation_sequencer

// ---- rtl/link_mode_resolver.sv ----
`timescale 1ns/100ps
module link_mode_resolver (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic an_enable,
  input wire logic neg_complete,
  input wire logic neg_failed,
  input wire logic [3:0] common,
  input wire logic force_100,
  input wire logic force_full,
  input wire logic xover_dis,
  input wire logic force_mdi,
  input wire logic mdi_detect,
  output logic speed_100,
  output logic full_duplex,
  output logic mdi_mode
);

  logic speed_q, speed_d;
  logic full_q, full_d;
  logic mdi_q, mdi_d;

  // pick speed, duplex and crossover
  always_comb begin
    speed_d = speed_q;
    full_d = full_q;
    if (!an_enable) begin
      speed_d = force_100;
      full_d = force_full;
    end else if (neg_complete) begin
      speed_d = common[3] | common[2];
      full_d = common[3] | (~common[2] & common[1]);
    end else if (neg_failed) begin
      speed_d = force_100;
      full_d = force_full;
    end
    mdi_d = xover_dis ? force_mdi : mdi_detect;
  end

  // result registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      speed_q <= 1'b1;
      full_q <= 1'b1;
      mdi_q <= 1'b1;
    end else begin
      speed_q <= speed_d;
      full_q <= full_d;
      mdi_q <= mdi_d;
    end
  end

  assign speed_100 = speed_q;
  assign full_duplex = full_q;
  assign mdi_mode = mdi_q;

endmodule : link_mode_resolver

// ---- rtl/phy_mii_control_status_bank.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - loopback bit routes host transmit through the PHY back to host receive
// - negotiation off: speed bit one gives 100 Mbps, zero 10 Mbps; resets one
// - negotiation runs only while its enable bit is one; resets to one
// - writing one to the restart bit starts a fresh negotiation exchange
// - negotiation off or failed: duplex bit picks full or half; resets one
// - algorithm bit selects one of two crossover detection schemes; resets one
// - automatic crossover off: forced bit one gives MDI, zero gives MDI-X
// - crossover disable bit turns automatic MDI/MDI-X detection off
// - transmit disable bit stops line transmit signalling while set
// - LED disable bit turns every link and activity indicator off
// - status word carries fixed read-only speed and duplex capability flags
// - negotiation complete bit is one only once negotiation has finished
// - link status bit reads one while link is up, zero when down
// - read-only bits report negotiation capability and extended register capability
// - identifier split into fixed low and high read-only words
// - pause is advertised to the partner only while its bit is one
// - four advertise bits offer 100/10 full/half abilities; all reset one
module phy_mii_control_status_bank #(
  parameter logic [15:0] ID_LOW = 16'h5A5A, // arbitrary value
  parameter logic [15:0] ID_HIGH = 16'hA5C3 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input phy_bank_pkg::reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic link_up,
  input wire logic partner_valid,
  input wire logic [4:0] partner_ability,
  input wire logic mdi_detect,
  input wire logic [3:0] led_raw,
  output logic loopback_en,
  output logic speed_100,
  output logic full_duplex,
  output logic an_enable,
  output logic an_complete,
  output logic pause_agreed,
  output logic [4:0] adv_ability,
  output logic xover_algo,
  output logic xover_auto_en,
  output logic mdi_mode,
  output logic tx_disable,
  output logic [3:0] led_out
);

  phy_bank_pkg::ctrl_s ctrl_q, ctrl_d;
  logic restart_q, restart_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [3:0] led_q, led_d;
  logic neg_complete;
  logic neg_failed;
  logic [3:0] common;
  logic [15:0] bc_word;
  logic [15:0] bs_word;
  logic [15:0] ad_word;
  logic [15:0] pc_word;
  logic [15:0] wmerge;

  // byte-lane merge of a write into the current word
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] be
  );
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : lane_merge

  // true for a write to the given address
  function automatic logic hit_wr(
    input phy_bank_pkg::reg_req_s q,
    input logic [7:0] ofs
  );
    return q.wr && (q.addr == ofs);
  endfunction : hit_wr

  // basic control view of the shared storage
  always_comb begin
    bc_word = 16'h0000;
    bc_word[phy_bank_pkg::BC_LOOPBACK] = ctrl_q.loopback;
    bc_word[phy_bank_pkg::BC_FORCE_100] = ctrl_q.force_100;
    bc_word[phy_bank_pkg::BC_AN_ENABLE] = ctrl_q.an_enable;
    bc_word[phy_bank_pkg::BC_RSVD_11] = ctrl_q.bc_rsvd[2];
    bc_word[phy_bank_pkg::BC_RSVD_10] = ctrl_q.bc_rsvd[1];
    bc_word[phy_bank_pkg::BC_AN_RESTART] = restart_q;
    bc_word[phy_bank_pkg::BC_FORCE_FULL] = ctrl_q.force_full;
    bc_word[phy_bank_pkg::BC_XOVER_ALGO] = ctrl_q.xover_algo;
    bc_word[phy_bank_pkg::BC_FORCE_MDI] = ctrl_q.force_mdi;
    bc_word[phy_bank_pkg::BC_XOVER_DIS] = ctrl_q.xover_dis;
    bc_word[phy_bank_pkg::BC_RSVD_2] = ctrl_q.bc_rsvd[0];
    bc_word[phy_bank_pkg::BC_TX_DIS] = ctrl_q.tx_dis;
    bc_word[phy_bank_pkg::BC_LED_DIS] = ctrl_q.led_dis;
  end

  // status view: fixed flags plus live state
  always_comb begin
    bs_word = phy_bank_pkg::BASIC_STATUS_FIXED;
    bs_word[phy_bank_pkg::BS_AN_DONE] = neg_complete;
    bs_word[phy_bank_pkg::BS_LINK_UP] = link_up;
  end

  // advertisement view
  always_comb begin
    ad_word = 16'h0000;
    ad_word[phy_bank_pkg::AD_PAUSE] = ctrl_q.adv_pause;
    ad_word[phy_bank_pkg::AD_RSVD_9] = ctrl_q.adv_rsvd;
    ad_word[phy_bank_pkg::AD_ABIL_LSB +: 4] = ctrl_q.adv_abil;
    ad_word[4:0] = phy_bank_pkg::SELECTOR_FIELD;
  end

  // port control view, aliasing the same storage
  always_comb begin
    pc_word = 16'h0000;
    pc_word[phy_bank_pkg::PC_LED_OFF] = ctrl_q.led_dis;
    pc_word[phy_bank_pkg::PC_TX_DIS] = ctrl_q.tx_dis;
    pc_word[phy_bank_pkg::PC_AN_RESTART] = restart_q;
    pc_word[phy_bank_pkg::PC_RSVD_12] = ctrl_q.pc_rsvd[2];
    pc_word[phy_bank_pkg::PC_RSVD_11] = ctrl_q.pc_rsvd[1];
    pc_word[phy_bank_pkg::PC_XOVER_DIS] = ctrl_q.xover_dis;
    pc_word[phy_bank_pkg::PC_FORCE_MDI] = ctrl_q.force_mdi;
    pc_word[phy_bank_pkg::PC_RSVD_8] = ctrl_q.pc_rsvd[0];
    pc_word[phy_bank_pkg::PC_AN_ENABLE] = ctrl_q.an_enable;
    pc_word[phy_bank_pkg::PC_FORCE_100] = ctrl_q.force_100;
    pc_word[phy_bank_pkg::PC_FORCE_FULL] = ctrl_q.force_full;
    pc_word[phy_bank_pkg::PC_PAUSE] = ctrl_q.adv_pause;
    pc_word[3:0] = ctrl_q.adv_abil;
  end

  // register writes into the shared storage
  always_comb begin
    ctrl_d = ctrl_q;
    restart_d = 1'b0; // restart self-clears after one cycle
    wmerge = 16'h0000;
    if (hit_wr(reg_req, phy_bank_pkg::OFS_BASIC_CONTROL)) begin
      wmerge = lane_merge(bc_word, reg_req.wdata, reg_req.be);
      ctrl_d.loopback = wmerge[phy_bank_pkg::BC_LOOPBACK];
      ctrl_d.force_100 = wmerge[phy_bank_pkg::BC_FORCE_100];
      ctrl_d.an_enable = wmerge[phy_bank_pkg::BC_AN_ENABLE];
      ctrl_d.bc_rsvd[2] = wmerge[phy_bank_pkg::BC_RSVD_11];
      ctrl_d.bc_rsvd[1] = wmerge[phy_bank_pkg::BC_RSVD_10];
      restart_d = reg_req.be[1] & reg_req.wdata[phy_bank_pkg::BC_AN_RESTART];
      ctrl_d.force_full = wmerge[phy_bank_pkg::BC_FORCE_FULL];
      ctrl_d.xover_algo = wmerge[phy_bank_pkg::BC_XOVER_ALGO];
      ctrl_d.force_mdi = wmerge[phy_bank_pkg::BC_FORCE_MDI];
      ctrl_d.xover_dis = wmerge[phy_bank_pkg::BC_XOVER_DIS];
      ctrl_d.bc_rsvd[0] = wmerge[phy_bank_pkg::BC_RSVD_2];
      ctrl_d.tx_dis = wmerge[phy_bank_pkg::BC_TX_DIS];
      ctrl_d.led_dis = wmerge[phy_bank_pkg::BC_LED_DIS];
    end else if (hit_wr(reg_req, phy_bank_pkg::OFS_ADVERTISE)) begin
      wmerge = lane_merge(ad_word, reg_req.wdata, reg_req.be);
      ctrl_d.adv_pause = wmerge[phy_bank_pkg::AD_PAUSE];
      ctrl_d.adv_rsvd = wmerge[phy_bank_pkg::AD_RSVD_9];
      ctrl_d.adv_abil = wmerge[phy_bank_pkg::AD_ABIL_LSB +: 4];
    end else if (hit_wr(reg_req, phy_bank_pkg::OFS_PORT_CONTROL)) begin
      wmerge = lane_merge(pc_word, reg_req.wdata, reg_req.be);
      ctrl_d.led_dis = wmerge[phy_bank_pkg::PC_LED_OFF];
      ctrl_d.tx_dis = wmerge[phy_bank_pkg::PC_TX_DIS];
      restart_d = reg_req.be[1] & reg_req.wdata[phy_bank_pkg::PC_AN_RESTART];
      ctrl_d.pc_rsvd[2] = wmerge[phy_bank_pkg::PC_RSVD_12];
      ctrl_d.pc_rsvd[1] = wmerge[phy_bank_pkg::PC_RSVD_11];
      ctrl_d.xover_dis = wmerge[phy_bank_pkg::PC_XOVER_DIS];
      ctrl_d.force_mdi = wmerge[phy_bank_pkg::PC_FORCE_MDI];
      ctrl_d.pc_rsvd[0] = wmerge[phy_bank_pkg::PC_RSVD_8];
      ctrl_d.an_enable = wmerge[phy_bank_pkg::PC_AN_ENABLE];
      ctrl_d.force_100 = wmerge[phy_bank_pkg::PC_FORCE_100];
      ctrl_d.force_full = wmerge[phy_bank_pkg::PC_FORCE_FULL];
      ctrl_d.adv_pause = wmerge[phy_bank_pkg::PC_PAUSE];
      ctrl_d.adv_abil = wmerge[3:0];
    end
  end

  // control storage registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q.loopback <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_LOOPBACK];
      ctrl_q.force_100 <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_FORCE_100];
      ctrl_q.an_enable <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_AN_ENABLE];
      ctrl_q.bc_rsvd <= 3'h0;
      ctrl_q.force_full <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_FORCE_FULL];
      ctrl_q.xover_algo <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_XOVER_ALGO];
      ctrl_q.force_mdi <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_FORCE_MDI];
      ctrl_q.xover_dis <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_XOVER_DIS];
      ctrl_q.tx_dis <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_TX_DIS];
      ctrl_q.led_dis <= phy_bank_pkg::BASIC_CONTROL_RST[phy_bank_pkg::BC_LED_DIS];
      ctrl_q.adv_pause <= phy_bank_pkg::ADVERTISE_RST[phy_bank_pkg::AD_PAUSE];
      ctrl_q.adv_rsvd <= phy_bank_pkg::ADVERTISE_RST[phy_bank_pkg::AD_RSVD_9];
      ctrl_q.adv_abil <= phy_bank_pkg::ADV_ABIL_RST;
      ctrl_q.pc_rsvd <= 3'h0;
      restart_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      restart_q <= restart_d;
    end
  end

  // read answer, one cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    rvalid_d = reg_req.rd;
    if (reg_req.rd) begin
      case (reg_req.addr)
        phy_bank_pkg::OFS_BASIC_CONTROL: rdata_d = bc_word;
        phy_bank_pkg::OFS_BASIC_STATUS: rdata_d = bs_word;
        phy_bank_pkg::OFS_ID_LOW: rdata_d = ID_LOW;
        phy_bank_pkg::OFS_ID_HIGH: rdata_d = ID_HIGH;
        phy_bank_pkg::OFS_ADVERTISE: rdata_d = ad_word;
        phy_bank_pkg::OFS_PORT_CONTROL: rdata_d = pc_word;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // read data registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // negotiation exchange
  negotiation_sequencer u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .enable(ctrl_q.an_enable),
    .restart(restart_q),
    .link_up(link_up),
    .partner_valid(partner_valid),
    .partner_ability(partner_ability),
    .local_ability(adv_ability),
    .complete(neg_complete),
    .failed(neg_failed),
    .pause_agreed(pause_agreed),
    .common(common)
  );

  // speed, duplex and crossover resolution
  link_mode_resolver u_res (
    .clk(clk),
    .rst_n(rst_n),
    .an_enable(ctrl_q.an_enable),
    .neg_complete(neg_complete),
    .neg_failed(neg_failed),
    .common(common),
    .force_100(ctrl_q.force_100),
    .force_full(ctrl_q.force_full),
    .xover_dis(ctrl_q.xover_dis),
    .force_mdi(ctrl_q.force_mdi),
    .mdi_detect(mdi_detect),
    .speed_100(speed_100),
    .full_duplex(full_duplex),
    .mdi_mode(mdi_mode)
  );

  // indicators, each forced high while disabled
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_led
      always_comb begin
        led_d[gi] = ctrl_q.led_dis ? 1'b1 : led_raw[gi];
      end
    end
  endgenerate

  // indicator registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      led_q <= 4'hF;
    end else begin
      led_q <= led_d;
    end
  end

  // datapath steering outputs
  assign loopback_en = ctrl_q.loopback;
  assign an_enable = ctrl_q.an_enable;
  assign an_complete = neg_complete;
  assign adv_ability = {ctrl_q.adv_pause, ctrl_q.adv_abil};
  assign xover_algo = ctrl_q.xover_algo;
  assign xover_auto_en = ~ctrl_q.xover_dis;
  assign tx_disable = ctrl_q.tx_dis;
  assign led_out = led_q;
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

endmodule : phy_mii_control_status_bank

// ---- testbench/phy_bank_asserts.sv ----
`timescale 1ns/100ps
module phy_bank_asserts #(
  parameter logic [15:0] ID_LOW = 16'h5A5A,
  parameter logic [15:0] ID_HIGH = 16'hA5C3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire phy_bank_pkg::reg_req_s reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic link_up,
  input wire logic [3:0] led_raw,
  input wire logic loopback_en,
  input wire logic an_enable,
  input wire logic an_complete,
  input wire logic pause_agreed,
  input wire logic [4:0] adv_ability,
  input wire logic tx_disable,
  input wire logic [3:0] led_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd_st;
  logic wr_bc;
  logic wr_pc;
  logic wr_ad;
  // decoded accesses
  assign rd_st = reg_req.rd && reg_req.addr == phy_bank_pkg::OFS_BASIC_STATUS;
  assign wr_bc = reg_req.wr && reg_req.addr == phy_bank_pkg::OFS_BASIC_CONTROL;
  assign wr_pc = reg_req.wr && reg_req.addr == phy_bank_pkg::OFS_PORT_CONTROL;
  assign wr_ad = reg_req.wr && reg_req.addr == phy_bank_pkg::OFS_ADVERTISE;
  property p_rd_answer; reg_req.rd |=> reg_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_spurious; !reg_req.rd |=> !reg_rvalid; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
  property p_id_low;
    reg_req.rd && reg_req.addr == phy_bank_pkg::OFS_ID_LOW |=> reg_rdata == ID_LOW;
  endproperty
  a_id_low: assert property (p_id_low) else $error("low id wrong");
  property p_id_high;
    reg_req.rd && reg_req.addr == phy_bank_pkg::OFS_ID_HIGH |=> reg_rdata == ID_HIGH;
  endproperty
  a_id_high: assert property (p_id_high) else $error("high id wrong");
  property p_status_fixed;
    rd_st |=> (reg_rdata & 16'hFFDB) == phy_bank_pkg::BASIC_STATUS_FIXED;
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status flags");
  property p_link_bit; rd_st |=> reg_rdata[2] == $past(link_up); endproperty
  a_link_bit: assert property (p_link_bit) else $error("link bit wrong");
  property p_done_bit; rd_st |=> reg_rdata[5] == $past(an_complete); endproperty
  a_done_bit: assert property (p_done_bit) else $error("done bit wrong");
  property p_loopback;
    wr_bc && reg_req.be[1] |=> loopback_en == $past(reg_req.wdata[14]);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback not set");
  property p_tx_alias;
    wr_pc && reg_req.be[1] |=> tx_disable == $past(reg_req.wdata[14]);
  endproperty
  a_tx_alias: assert property (p_tx_alias) else $error("alias tx wrong");
  property p_advert;
    wr_ad && reg_req.be == 2'h3 |=>
      adv_ability == {$past(reg_req.wdata[10]), $past(reg_req.wdata[8:5])};
  endproperty
  a_advert: assert property (p_advert) else $error("advertise wrong");
  property p_restart;
    wr_bc && reg_req.be[1] && reg_req.wdata[9] |-> ##[1:3] !an_complete;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");
  property p_an_off; !an_enable && $past(!an_enable) |-> !an_complete; endproperty
  a_an_off: assert property (p_an_off) else $error("done while disabled");
  property p_pause; !an_complete && $past(!an_complete) |-> !pause_agreed; endproperty
  a_pause: assert property (p_pause) else $error("pause without done");
  property p_led; led_out == 4'hF || led_out == $past(led_raw); endproperty
  a_led: assert property (p_led) else $error("indicator wrong");
  c_done: cover property (an_complete);
  c_pause: cover property (pause_agreed);
  c_loop: cover property (loopback_en);
endmodule : phy_bank_asserts

bind phy_mii_control_status_bank phy_bank_asserts #(.ID_LOW(ID_LOW), .ID_HIGH(ID_HIGH))
  i_phy_bank_asserts (.clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .link_up, .led_raw,
  .loopback_en, .an_enable, .an_complete, .pause_agreed, .adv_ability, .tx_disable, .led_out);

// ---- testbench/link_partner_model.sv ----
`timescale 1ns/100ps
module link_partner_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic offer,
  input wire logic up,
  input wire logic [1:0] lag,
  input wire logic [4:0] ability,
  output logic link_up,
  output logic partner_valid,
  output logic [4:0] partner_ability,
  output logic mdi_detect,
  output logic [3:0] led_raw
);
  logic [7:0] cnt_q;
  logic [1:0] wait_q;
  // free pattern and answer delay after an offer
  always_ff @(posedge clk) begin
    cnt_q <= rst_n ? cnt_q + 8'h01 : 8'h00;
    if (!offer) wait_q <= 2'h0;
    else if (wait_q != lag) wait_q <= wait_q + 2'h1;
  end
  // ability word stands only once an offer has waited out its lag, else a moving pattern
  assign partner_valid = offer && wait_q == lag;
  assign partner_ability = partner_valid ? ability : cnt_q[4:0];
  assign link_up = up;
  assign mdi_detect = cnt_q[5];
  assign led_raw = cnt_q[3:0];
endmodule : link_partner_model

// ---- testbench/tb_phy_mii_control_status_bank.sv ----
`timescale 1ns/100ps
module tb_phy_mii_control_status_bank;
  localparam logic [15:0] ID_LO = 16'h1234; // arbitrary value
  localparam logic [15:0] ID_HI = 16'h4321; // arbitrary value
  localparam logic [7:0] BC = phy_bank_pkg::OFS_BASIC_CONTROL;
  localparam logic [7:0] BS = phy_bank_pkg::OFS_BASIC_STATUS;
  localparam logic [7:0] AD = phy_bank_pkg::OFS_ADVERTISE;
  localparam logic [7:0] PC = phy_bank_pkg::OFS_PORT_CONTROL;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  phy_bank_pkg::reg_req_s reg_req = '0;
  logic [15:0] reg_rdata;
  logic reg_rvalid, link_up, partner_valid, mdi_detect, loopback_en, speed_100, full_duplex;
  logic an_enable, an_complete, pause_agreed, xover_algo, xover_auto_en, mdi_mode, tx_disable;
  logic [4:0] partner_ability, adv_ability;
  logic [4:0] ability = 5'h00;
  logic [3:0] led_raw, led_out;
  logic offer = 1'b0;
  logic up = 1'b0;
  logic [1:0] lag = 2'h0;
  logic [15:0] exp_q[$];
  logic [9:0] nt [6] = '{10'h3FF, 10'h218, 10'h306, 10'h32B, 10'h1FE, 10'h24C};
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;

  phy_mii_control_status_bank #(.ID_LOW(ID_LO), .ID_HIGH(ID_HI)) i_phy_mii_control_status_bank (
    .clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .link_up, .partner_valid, .partner_ability,
    .mdi_detect, .led_raw, .loopback_en, .speed_100, .full_duplex, .an_enable, .an_complete,
    .pause_agreed, .adv_ability, .xover_algo, .xover_auto_en, .mdi_mode, .tx_disable, .led_out);
  link_partner_model i_link_partner_model (.clk, .rst_n, .offer, .up, .lag, .ability, .link_up,
    .partner_valid, .partner_ability, .mdi_detect, .led_raw);

  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    total_checks++;
    if (got !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  task automatic results();
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // one bus cycle, driven just after the edge
  task automatic op(input logic r, input logic w, input logic [7:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    reg_req = '{rd: r, wr: w, addr: a, be: be, wdata: d};
    @(posedge clk);
    #1;
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    op(1'b0, 1'b1, a, be, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    op(1'b1, 1'b0, a, 2'h0, 16'h0000);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 2'h0, 16'h0000);
  endtask : idle

  // restart, offer partner ability, judge the outcome {done,100,full,pause}
  task automatic neg(input logic [9:0] t);
    wr(AD, 2'h3, t[9] ? 16'h05E1 : 16'h01E1);
    wr(BC, 2'h3, 16'h3320);
    rd(BC, 16'h3320);
    ability = t[8:4];
    lag = 2'($urandom());
    offer = 1'b1;
    for (int k = 0; k < 40 && an_complete !== 1'b1; k++) idle(1);
    idle(3);
    chk("neg", {12'h000, an_complete, speed_100, full_duplex, pause_agreed}, {12'h000, t[3:0]});
    rd(BS, t[3] ? 16'h3074 : 16'h3054);
    offer = 1'b0;
  endtask : neg

  // answer checker, oldest note first
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious", 16'h0000, 16'h0001);
      else chk("rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end

  initial begin
    logic [15:0] v;
    logic [2:0] n;
    void'($urandom(2797));
    repeat (20) @(posedge clk);
    #1;
    // reset values, seen while reset still holds
    chk("rst", {2'b00, loopback_en, speed_100, full_duplex, an_enable, an_complete, pause_agreed,
        xover_algo, xover_auto_en, mdi_mode, tx_disable, led_out}, 16'h1CEF);
    chk("adv", {11'h000, adv_ability}, 16'h001F);
    rst_n = 1'b1;
    idle(1);
    rd(BC, phy_bank_pkg::BASIC_CONTROL_RST);
    rd(BS, phy_bank_pkg::BASIC_STATUS_FIXED);
    rd(phy_bank_pkg::OFS_ID_LOW, ID_LO);
    rd(phy_bank_pkg::OFS_ID_HIGH, ID_HI);
    rd(AD, phy_bank_pkg::ADVERTISE_RST);
    rd(PC, 16'h00FF);
    rd(8'hE0, 16'h0000);
    // read-only words and fields ignore writes
    wr(BS, 2'h3, 16'hFFFF);
    wr(phy_bank_pkg::OFS_ID_LOW, 2'h3, 16'hFFFF);
    wr(AD, 2'h3, 16'hFFFF);
    rd(BS, phy_bank_pkg::BASIC_STATUS_FIXED);
    rd(phy_bank_pkg::OFS_ID_LOW, ID_LO);
    rd(AD, 16'h07E1);
    wr(AD, 2'h1, 16'h0000);
    rd(AD, 16'h0701);
    wr(AD, 2'h3, 16'h0000);
    rd(AD, 16'h0001);
    wr(AD, 2'h3, phy_bank_pkg::ADVERTISE_RST);
    // random control words, forced modes swept
    for (int i = 0; i < 8; i++) begin
      n = 3'(i);
      v = (16'($urandom()) & 16'hCCE7) |
          {2'b00, n[0], n[2], 3'h0, n[1], 3'h0, n[0] ^ n[1], !n[2], 3'h0};
      wr(BC, 2'h3, v);
      chk("ctl", {11'h000, loopback_en, an_enable, xover_algo, xover_auto_en, tx_disable},
          {11'h000, v[14], v[12], v[5], !v[3], v[1]});
      rd(BC, v & 16'h7D3F);
      rd(PC, {v[0], v[1], 3'h0, v[3], v[4], 1'b0, v[12], v[13], v[8], 5'h1F});
      idle(1);
      if (!n[2]) chk("frc", {13'h0000, speed_100, full_duplex, mdi_mode}, {13'h0000, v[13], v[8], v[4]});
      if (v[0]) chk("led", {12'h000, led_out}, 16'h000F);
    end
    wr(BC, 2'h3, phy_bank_pkg::BASIC_CONTROL_RST);
    wr(PC, 2'h3, 16'hC0FF);
    rd(BC, 16'h3123);
    wr(PC, 2'h3, 16'h00FF);
    rd(BC, phy_bank_pkg::BASIC_CONTROL_RST);
    // negotiation outcomes
    up = 1'b1;
    foreach (nt[j]) neg(nt[j]);
    up = 1'b0;
    idle(3);
    rd(BS, phy_bank_pkg::BASIC_STATUS_FIXED);
    wr(BC, 2'h3, 16'h2120);
    rd(BC, 16'h2120);
    idle(3);
    results();
  end
endmodule : tb_phy_mii_control_status_bank
